// ===== bench/ebms_ext_mem.sv
// external memory on the multiplexed bus, far side of ebms_top
// assumes chip select high through address and data phases
`timescale 1ns/100ps
`default_nettype none
module ebms_ext_mem (
  input  wire logic        clk_i,
  input  wire logic        cs_i,
  input  wire logic        rnw_i,
  input  wire logic [15:0] ad_i,
  output logic      [15:0] ad_o
);
  logic [15:0] mem_q [16];
  logic [15:0] addr_q = 16'h0000;
  logic [15:0] last_q = 16'h0000;
  logic        cs_q   = 1'b0;
  initial for (int i = 0; i < 16; i++) mem_q[i] = 16'h1000 + 16'(i);
  // outside the data phase the lines show a moving pattern, not old data
  assign ad_o = (cs_i && cs_q && rnw_i) ? mem_q[addr_q[4:1]] : ~last_q;
  always @(posedge clk_i) begin
    cs_q <= cs_i;
    last_q <= ad_o;
    if (cs_i && !cs_q) addr_q <= ad_i;
    if (cs_i && cs_q && !rnw_i) mem_q[addr_q[4:1]] <= ad_i;
  end
endmodule
`default_nettype wire

// ===== bench/ebms_top_sva.sv
// checker for ebms_top, sees only its ports
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module ebms_top_sva (
  input wire logic        CLK_SYS_I,
  input wire logic        RESETN_I,
  input wire logic [3:0]  REG_ADDR_I,
  input wire logic [7:0]  REG_WDATA_I,
  input wire logic        REG_WR_I,
  input wire logic [7:0]  REG_RDATA_O,
  input wire logic        REG_ECHO_O,
  input wire logic        MODE_SELECT_PIN_C_I,
  input wire logic        MODE_SELECT_PIN_B_I,
  input wire logic        MODE_SELECT_PIN_A_I,
  input wire logic        BDM_ENABLE_CMD_I,
  input wire logic        BDM_ACTIVE_O,
  input wire logic        PIPE_STATUS_OE_O,
  input wire logic [7:0]  PORT_K_PIN_OE_O,
  input wire logic        BUS_REQ_I,
  input wire logic        BUS_WR_I,
  input wire logic        BUS_WIDE_I,
  input wire logic        BUS_RAM_I,
  input wire logic [15:0] BUS_ADDR_I,
  input wire logic [1:0]  STRETCH_CNT_I,
  input wire logic        BUS_READY_O,
  input wire logic        CPU_HOLD_O,
  input wire logic [15:0] BUS_RDATA_O,
  input wire logic        BUS_RDATA_VALID_O,
  input wire logic        REF_TICK_O,
  input wire logic [15:0] EXT_AD_I,
  input wire logic        LOW_BYTE_STROBE_N_O,
  input wire logic        ADDRESS_BIT_ZERO_O,
  input wire logic        READ_NOT_WRITE_O,
  input wire logic        CHIP_SELECT_O
);
  logic       busy_q, wr_q, wide_q, ram_q, a0_q;
  logic [2:0] cnt_q;
  logic [1:0] s_q;
  wire        take = BUS_READY_O && BUS_REQ_I;
  // shadow of the cycle in flight, so timing is judged against its cause
  always @(posedge CLK_SYS_I) begin
    busy_q <= RESETN_I && (take || (busy_q && !BUS_READY_O));
    cnt_q <= take ? 3'd1 : cnt_q + 3'd1;
    if (cnt_q == 3'd1) s_q <= STRETCH_CNT_I;
    if (take) begin
      wr_q <= BUS_WR_I;
      wide_q <= BUS_WIDE_I;
      ram_q <= BUS_RAM_I;
      a0_q <= BUS_ADDR_I[0];
    end
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  a_dir_write: assert property (REG_WR_I && REG_ADDR_I == 4'h0 |=>
    (REG_ECHO_O ? $stable(PORT_K_PIN_OE_O)
                : PORT_K_PIN_OE_O == $past(REG_WDATA_I)))
    else $error("direction write not applied as expected");
  a_echo_quiet: assert property (REG_ECHO_O |-> REG_RDATA_O == 8'h00)
    else $error("echoed access returned register data");
  a_narrow_code: assert property (CHIP_SELECT_O && busy_q && !wide_q |->
    ADDRESS_BIT_ZERO_O == a0_q && LOW_BYTE_STROBE_N_O == !a0_q)
    else $error("byte access encoding wrong");
  a_both_high: assert property (CHIP_SELECT_O && LOW_BYTE_STROBE_N_O &&
    ADDRESS_BIT_ZERO_O |-> busy_q && wide_q && ram_q)
    else $error("strobe and bit zero high outside ram word access");
  a_cycle_len: assert property (busy_q && BUS_READY_O |->
    cnt_q == 3'd3 + {1'b0, s_q})
    else $error("bus cycle length differs from stretch");
  a_hold_span: assert property (CPU_HOLD_O == (busy_q && cnt_q >= 3'd2 &&
    cnt_q < 3'd2 + {1'b0, s_q}))
    else $error("cpu hold span wrong");
  a_cs_rw: assert property (busy_q && !BUS_READY_O |-> CHIP_SELECT_O &&
    READ_NOT_WRITE_O == !wr_q)
    else $error("select or direction dropped in cycle");
  a_read_edge: assert property (BUS_RDATA_VALID_O |-> busy_q && !wr_q &&
    BUS_READY_O && (BUS_RDATA_O == $past(EXT_AD_I) || (wide_q && a0_q)))
    else $error("read data not taken at end of data phase");
  a_ref_tick: assert property ($past(RESETN_I) |->
    REF_TICK_O != $past(REF_TICK_O))
    else $error("reference tick missed a toggle");
  a_bdm_start: assert property ($rose(RESETN_I) && !BDM_ENABLE_CMD_I |=>
    BDM_ACTIVE_O == ({MODE_SELECT_PIN_C_I, MODE_SELECT_PIN_B_I,
                      MODE_SELECT_PIN_A_I} == 3'h0))
    else $error("debug activity at reset exit wrong");
  a_pipe_float: assert property (disable iff (1'b0)
    !RESETN_I |-> !PIPE_STATUS_OE_O)
    else $error("pipe status driven during reset");
  c_long: cover property (busy_q && BUS_READY_O && s_q == 2'h3);
  c_echo: cover property (REG_ECHO_O);
  c_read: cover property (BUS_RDATA_VALID_O && wide_q && ram_q);
endmodule
bind ebms_top ebms_top_sva i_sva (.*);
`default_nettype wire

// ===== bench/ebms_top_test.sv
// self-checking bench for ebms_top with an external memory model
// assumes the design map header on the include path
`timescale 1ns/100ps
`default_nettype none
`include "ebms_map.vh"
module ebms_top_test;
  typedef struct packed {
    logic wr, wide, ram;
    logic [1:0] s;
    logic [15:0] addr, wdata, exp;
  } ebms_row_t;
  logic CLK_SYS_I = 1'b0, RESETN_I = 1'b0, REG_WR_I = 1'b0, REG_RD_I = 1'b0;
  logic [3:0] REG_ADDR_I = 4'h0;
  logic [7:0] REG_WDATA_I = 8'h00, PORT_K_PIN_I = 8'h3c;
  logic [7:0] REG_RDATA_O, PORT_K_PIN_O, PORT_K_PIN_OE_O, d;
  logic MODE_SELECT_PIN_C_I = 1'b1, MODE_SELECT_PIN_B_I = 1'b1;
  logic MODE_SELECT_PIN_A_I = 1'b1, IRQ_ENABLE_I = 1'b0;
  logic NONMASKABLE_INTERRUPT_INPUT_ENABLE_I = 1'b0, BDM_ENABLE_CMD_I = 1'b0, BUS_REQ_I = 1'b0;
  logic BUS_WR_I = 1'b0, BUS_WIDE_I = 1'b0, BUS_RAM_I = 1'b0, e;
  logic [1:0] PIPE_STATE_I = 2'h2, PORT_E_PIN_I = 2'h3, STRETCH_CNT_I = 2'h0;
  logic [1:0] PORT_E_PULLUP_O;
  logic [15:0] BUS_ADDR_I = 16'h0000, BUS_WDATA_I = 16'h0000;
  logic [15:0] BUS_RDATA_O, EXT_AD_I, EXT_AD_O;
  logic REG_ECHO_O, PIPE_STATUS_HIGH_O, PIPE_STATUS_LOW_O, PIPE_STATUS_OE_O;
  logic MASKABLE_IRQ_N_O, NONMASKABLE_IRQ_N_O, BDM_ACTIVE_O, BUS_READY_O;
  logic CPU_HOLD_O, BUS_RDATA_VALID_O, REF_TICK_O, EXT_AD_OE_O, E_CLOCK_O;
  logic LOW_BYTE_STROBE_N_O, ADDRESS_BIT_ZERO_O, READ_NOT_WRITE_O;
  logic CHIP_SELECT_O;
  int num_errors = 0, samples_checked = 0;
  ebms_row_t rows [6] = '{
    '{1'b1, 1'b1, 1'b0, 2'h0, 16'h0004, 16'hbeef, 16'h0000},
    '{1'b0, 1'b1, 1'b0, 2'h3, 16'h0004, 16'h0000, 16'hbeef},
    '{1'b0, 1'b1, 1'b1, 2'h1, 16'h0005, 16'h0000, 16'hefbe},
    '{1'b0, 1'b0, 1'b0, 2'h2, 16'h0003, 16'h0000, 16'h1001},
    '{1'b1, 1'b1, 1'b0, 2'h2, 16'h0010, 16'h1234, 16'h0000},
    '{1'b0, 1'b1, 1'b0, 2'h0, 16'h0010, 16'h0000, 16'h1234}};
  ebms_top i_dut (.*);
  ebms_ext_mem i_mem (.clk_i(CLK_SYS_I), .cs_i(CHIP_SELECT_O),
    .rnw_i(READ_NOT_WRITE_O), .ad_i(EXT_AD_O), .ad_o(EXT_AD_I));
  always #2.5 CLK_SYS_I = ~CLK_SYS_I;
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
    REG_ADDR_I <= a;
    REG_WDATA_I <= v;
    REG_WR_I <= 1'b1;
    @(posedge CLK_SYS_I);
    REG_WR_I <= 1'b0;
    @(posedge CLK_SYS_I);
  endtask
  task automatic reg_rd(input logic [3:0] a);
    REG_ADDR_I <= a;
    REG_RD_I <= 1'b1;
    @(posedge CLK_SYS_I);
    REG_RD_I <= 1'b0;
    #1 d = REG_RDATA_O;
    e = REG_ECHO_O;
    @(posedge CLK_SYS_I);
  endtask
  task automatic bus_op(input ebms_row_t r);
    int n;
    {BUS_WR_I, BUS_WIDE_I, BUS_RAM_I} <= {r.wr, r.wide, r.ram};
    STRETCH_CNT_I <= r.s;
    {BUS_REQ_I, BUS_ADDR_I, BUS_WDATA_I} <= {1'b1, r.addr, r.wdata};
    @(posedge CLK_SYS_I);
    BUS_REQ_I <= 1'b0;
    #1 chk(16'(E_CLOCK_O), 16'h0000);
    n = 0;
    do begin
      @(posedge CLK_SYS_I);
      n++;
      #1;
    end while (BUS_READY_O !== 1'b1 && n < 12);
    if (n >= 12) begin
      num_errors++;
      give_verdict();
    end
    chk(16'(n), 16'h0002 + 16'(r.s));
    chk(16'(BUS_RDATA_VALID_O), 16'(!r.wr));
    if (!r.wr) chk(BUS_RDATA_O, r.exp);
    @(posedge CLK_SYS_I);
  endtask
  initial begin
    #400000 num_errors++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge CLK_SYS_I);
    RESETN_I <= 1'b1;
    repeat (2) @(posedge CLK_SYS_I);
    reg_rd(`EBMS_OFS_PORT_K_OUTPUT_LATCH_DIR);
    chk(16'(d), 16'h0000);
    reg_rd(`EBMS_OFS_BUS_CTL);
    chk(16'(d), 16'h000d);
    reg_rd(`EBMS_OFS_MODE);
    chk(16'(d), 16'h00e0);
    reg_rd(`EBMS_OFS_STATUS);
    chk(16'(d[0]), 16'h0000);
    reg_rd(4'hf);
    chk(16'(d), 16'h0000);
    chk(16'(PORT_E_PULLUP_O), 16'h0003);
    IRQ_ENABLE_I <= 1'b1;
    PORT_E_PIN_I <= 2'h1;
    @(posedge CLK_SYS_I);
    chk(16'({MASKABLE_IRQ_N_O, NONMASKABLE_IRQ_N_O}), 16'h0001);
    reg_wr(`EBMS_OFS_PORT_K_OUTPUT_LATCH_DATA, 8'hf0);
    reg_wr(`EBMS_OFS_PORT_K_OUTPUT_LATCH_DIR, 8'ha5);
    chk(16'(PORT_K_PIN_OE_O), 16'h00a5);
    @(posedge CLK_SYS_I);
    reg_rd(`EBMS_OFS_PORT_K_OUTPUT_LATCH_DATA);
    chk(16'(d), 16'h00b8);
    $display("register reset and port k test done");
    foreach (rows[i]) bus_op(rows[i]);
    $display("bus cycle table done");
    // peripheral code must be refused and must not use up the one write
    reg_wr(`EBMS_OFS_MODE, 8'hc0);
    reg_wr(`EBMS_OFS_MODE, 8'he1);
    reg_rd(`EBMS_OFS_MODE);
    chk(16'(d), 16'h00e1);
    reg_wr(`EBMS_OFS_PORT_K_OUTPUT_LATCH_DIR, 8'h00);
    reg_rd(`EBMS_OFS_PORT_K_OUTPUT_LATCH_DIR);
    chk(16'({e, d}), 16'h0100);
    chk(16'(PORT_K_PIN_OE_O), 16'h00a5);
    $display("mode and echo test done");
    RESETN_I <= 1'b0;
    {MODE_SELECT_PIN_C_I, MODE_SELECT_PIN_B_I, MODE_SELECT_PIN_A_I} <= 3'h0;
    repeat (20) @(posedge CLK_SYS_I);
    RESETN_I <= 1'b1;
    repeat (2) @(posedge CLK_SYS_I);
    chk(16'(BDM_ACTIVE_O), 16'h0001);
    reg_rd(`EBMS_OFS_MODE);
    chk(16'(d), 16'h0000);
    reg_rd(`EBMS_OFS_BUS_CTL);
    chk(16'(d[0]), 16'h0001);
    $display("second reset test done");
    give_verdict();
  end
endmodule
`default_nettype wire

// ===== hdl/ebms_stretch.v
// stretch counter for the data phase of an external bus cycle
// assumes load is a one-cycle pulse in the address phase just before each data phase
`timescale 1ns/100ps
`default_nettype none
`include "ebms_map.vh"

module ebms_stretch (
  input  wire                        clk_i,
  input  wire                        rst_n_i,
  input  wire                        load_i,
  input  wire [`EBMS_STRETCH_W-1:0]  count_i,
  output wire                        expired_o
);

  reg [`EBMS_STRETCH_W-1:0] cnt_q;

  // -----------------------------------------------------------------
  // reload per data phase, then count down to zero
  // -----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= {`EBMS_STRETCH_W{1'b0}};
    end else if (load_i) begin
      cnt_q <= count_i;
    end else if (cnt_q != {`EBMS_STRETCH_W{1'b0}}) begin
      cnt_q <= cnt_q - {{(`EBMS_STRETCH_W-1){1'b0}}, 1'b1};
    end
  end

  // expiry releases the held cpu state
  assign expired_o = (cnt_q == {`EBMS_STRETCH_W{1'b0}}) && !load_i;

endmodule
`default_nettype wire

// ===== hdl/ebms_top.v
// external bus mode selection, port k direction and stretched cycles
// assumes a cpu that waits on BUS_READY_O and honours CPU_HOLD_O,
// and the stretch amount supplied by the mapping control logic
//
// Behaviour
// - port k direction bit one drives pin, zero floats it; resets zero
// - emulation enable in expanded or peripheral mode moves direction out
// - strobe, address bit zero and read/write encode width and alignment
// - only internal ram gives strobe and bit zero both high, bytes swapped
// - external cycles stretch by zero to three bus clocks
// - timer and baud reference tick never stretches
// - cpu held and write data kept driven during stretch
// - read data captured only at end of data phase, where the bus e clock falls
// - chip select and read/write valid throughout stretched e high
// - address phase keeps its normal single clock length
// - mode pins latched into mode bits when reset releases
// - mode codes zero to seven map to the eight operating modes
// - normal modes write protected controls once; special modes anytime
// - debug active at reset in special single chip mode, in other modes only when BDM_ENABLE_CMD_I is set
// - port e bit one plain pulled-up input until irq enabled
// - port e bit zero plain pulled-up input until nonmaskable_interrupt_input enabled
// - reset sets e clock stretch enable in every mode
// - pipe status pins float as mode inputs during reset
// - mode bits readable; only limited mode changes accepted
// - stretch bit clear gives free e clock; set gives bus e clock outside single chip modes
`timescale 1ns/100ps
`default_nettype none
`include "ebms_map.vh"

module ebms_top (
  input  wire                        CLK_SYS_I,
  input  wire                        RESETN_I,
  // register port
  input  wire [3:0]                  REG_ADDR_I,
  input  wire [7:0]                  REG_WDATA_I,
  input  wire                        REG_WR_I,
  input  wire                        REG_RD_I,
  output reg  [7:0]                  REG_RDATA_O,
  output reg                         REG_ECHO_O,
  // mode select pins, shared with pipe status outputs
  input  wire                        MODE_SELECT_PIN_C_I,
  input  wire                        MODE_SELECT_PIN_B_I,
  input  wire                        MODE_SELECT_PIN_A_I,
  input  wire [1:0]                  PIPE_STATE_I,
  output reg                         PIPE_STATUS_HIGH_O,
  output reg                         PIPE_STATUS_LOW_O,
  output wire                        PIPE_STATUS_OE_O,
  // port k
  input  wire [7:0]                  PORT_K_PIN_I,
  output wire [7:0]                  PORT_K_PIN_O,
  output wire [7:0]                  PORT_K_PIN_OE_O,
  // port e bits 1 and 0
  input  wire [1:0]                  PORT_E_PIN_I,
  input  wire                        IRQ_ENABLE_I,
  input  wire                        NONMASKABLE_INTERRUPT_INPUT_ENABLE_I,
  output wire [1:0]                  PORT_E_PULLUP_O,
  output wire                        MASKABLE_IRQ_N_O,
  output wire                        NONMASKABLE_IRQ_N_O,
  // debug
  input  wire                        BDM_ENABLE_CMD_I,
  output wire                        BDM_ACTIVE_O,
  // cpu side of the external bus
  input  wire                        BUS_REQ_I,
  input  wire                        BUS_WR_I,
  input  wire                        BUS_WIDE_I,
  input  wire                        BUS_RAM_I,
  input  wire [15:0]                 BUS_ADDR_I,
  input  wire [15:0]                 BUS_WDATA_I,
  input  wire [`EBMS_STRETCH_W-1:0]  STRETCH_CNT_I,
  output wire                        BUS_READY_O,
  output wire                        CPU_HOLD_O,
  output reg  [15:0]                 BUS_RDATA_O,
  output reg                         BUS_RDATA_VALID_O,
  output reg                         REF_TICK_O,
  // external pins of the multiplexed bus
  input  wire [15:0]                 EXT_AD_I,
  output reg  [15:0]                 EXT_AD_O,
  output wire                        EXT_AD_OE_O,
  output wire                        LOW_BYTE_STROBE_N_O,
  output wire                        ADDRESS_BIT_ZERO_O,
  output wire                        READ_NOT_WRITE_O,
  output wire                        CHIP_SELECT_O,
  output wire                        E_CLOCK_O
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ADDR = 2'h1;
  localparam [1:0] ST_DATA = 2'h2;
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  reg  [7:0]  port_k_pin_direction_q, port_k_output_latch_q;
  reg  [2:0]  mode_q;
  reg         memory_expansion_emulation_enable_q, e_clock_stretch_enable_q;
  reg         pipe_en_q, in_reset_q, mode_written_q, e_clock_stretch_enable_written_q;
  reg  [1:0]  pullup_q, state_q, state_d;
  reg         bdm_active_q, e_free_q, req_wr_q, req_wide_q, req_ram_q;
  reg  [15:0] req_addr_q, req_wdata_q;
  wire        special_mode, single_chip, expanded, dir_external;
  wire        data_load, stretch_done, swap, mode_change_ok;
  wire        sel_dir, sel_data, sel_mode, sel_ctl, sel_stat;
  wire [2:0]  mode_wr;
  wire [7:0]  port_k_read;

  // -----------------------------------------------------------------
  // mode decode
  // -----------------------------------------------------------------
  // special modes are special single chip and special test
  assign special_mode = !mode_q[2] && !mode_q[0];
  assign single_chip  = (mode_q[1:0] == 2'h0);
  // peripheral mode counts as expanded for the echo decision
  assign expanded     = !single_chip;

  // -----------------------------------------------------------------
  // register port decode
  // -----------------------------------------------------------------
  assign dir_external = memory_expansion_emulation_enable_q && expanded;
  assign sel_dir  = (REG_ADDR_I == `EBMS_OFS_PORT_K_OUTPUT_LATCH_DIR) && !dir_external;
  assign sel_data = (REG_ADDR_I == `EBMS_OFS_PORT_K_OUTPUT_LATCH_DATA) && !dir_external;
  assign sel_mode = (REG_ADDR_I == `EBMS_OFS_MODE);
  assign sel_ctl  = (REG_ADDR_I == `EBMS_OFS_BUS_CTL);
  assign sel_stat = (REG_ADDR_I == `EBMS_OFS_STATUS);
  assign mode_wr = REG_WDATA_I[`EBMS_MODE_HI_BIT:`EBMS_MODE_LO_BIT];
  // no crossing between normal and special, never into peripheral
  assign mode_change_ok = (mode_wr[2] == mode_q[2]) &&
                          (mode_wr != `EBMS_MD_PERIPHERAL) &&
                          (special_mode || !mode_written_q);
  // pin value when input, latch value when output
  assign port_k_read = (port_k_pin_direction_q & port_k_output_latch_q) |
                       (~port_k_pin_direction_q & PORT_K_PIN_I);

  // -----------------------------------------------------------------
  // registers written by software
  // -----------------------------------------------------------------
  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      port_k_pin_direction_q <= `EBMS_RST_PORT_K_OUTPUT_LATCH_DIR;
      port_k_output_latch_q  <= `EBMS_RST_PORT_K_OUTPUT_LATCH_DATA;
      memory_expansion_emulation_enable_q <= 1'b0;
      e_clock_stretch_enable_q <= `EBMS_RST_E_CLOCK_STRETCH_ENABLE;
      pipe_en_q              <= 1'b0;
      pullup_q               <= `EBMS_RST_PULLUP;
      mode_written_q         <= 1'b0;
      e_clock_stretch_enable_written_q         <= 1'b0;
    end else if (REG_WR_I) begin
      if (sel_dir) begin
        port_k_pin_direction_q <= REG_WDATA_I;
      end
      if (sel_data) begin
        port_k_output_latch_q <= REG_WDATA_I;
      end
      if (sel_mode && mode_change_ok) begin
        memory_expansion_emulation_enable_q <=
          REG_WDATA_I[`EBMS_MODE_EMK_BIT];
        mode_written_q <= 1'b1;
      end
      if (sel_ctl) begin
        if (special_mode || !e_clock_stretch_enable_written_q) begin
          e_clock_stretch_enable_q <= REG_WDATA_I[`EBMS_CTL_E_CLOCK_STRETCH_ENABLE_BIT];
          e_clock_stretch_enable_written_q <= 1'b1;
        end
        pipe_en_q <= REG_WDATA_I[`EBMS_CTL_PIPE_BIT];
        pullup_q  <= {REG_WDATA_I[`EBMS_CTL_PU1_BIT],
                      REG_WDATA_I[`EBMS_CTL_PU0_BIT]};
      end
    end
  end

  // -----------------------------------------------------------------
  // mode latch at reset release and debug activation
  // -----------------------------------------------------------------
  // synchronous reset: the pins are sampled on the first edge after
  // release, so the reset branch only loads constants
  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      in_reset_q   <= 1'b1;
      mode_q       <= `EBMS_RST_MODE;
      bdm_active_q <= 1'b0;
    end else if (in_reset_q) begin
      in_reset_q <= 1'b0;
      mode_q     <= {MODE_SELECT_PIN_C_I, MODE_SELECT_PIN_B_I,
                     MODE_SELECT_PIN_A_I};
      bdm_active_q <= ({MODE_SELECT_PIN_C_I, MODE_SELECT_PIN_B_I,
                        MODE_SELECT_PIN_A_I} == `EBMS_MD_SPEC_SINGLE) ||
                      BDM_ENABLE_CMD_I;
    end else begin
      if (REG_WR_I && sel_mode && mode_change_ok) begin
        mode_q <= mode_wr;
      end
      if (BDM_ENABLE_CMD_I) begin
        bdm_active_q <= 1'b1;
      end
    end
  end
  assign BDM_ACTIVE_O = bdm_active_q;
  // -----------------------------------------------------------------
  // read data, one cycle after the read strobe
  // -----------------------------------------------------------------
  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      REG_RDATA_O <= 8'h00;
      REG_ECHO_O  <= 1'b0;
    end else begin
      REG_RDATA_O <= 8'h00;
      // accesses to a register taken out of the map go to the bus
      REG_ECHO_O  <= (REG_RD_I || REG_WR_I) && dir_external &&
                     ((REG_ADDR_I == `EBMS_OFS_PORT_K_OUTPUT_LATCH_DIR) ||
                      (REG_ADDR_I == `EBMS_OFS_PORT_K_OUTPUT_LATCH_DATA));
      if (REG_RD_I) begin
        if (sel_dir) begin
          REG_RDATA_O <= port_k_pin_direction_q;
        end else if (sel_data) begin
          REG_RDATA_O <= port_k_read;
        end else if (sel_mode) begin
          REG_RDATA_O <= {mode_q, 4'h0,
                          memory_expansion_emulation_enable_q};
        end else if (sel_ctl) begin
          REG_RDATA_O <= {4'h0, pullup_q, pipe_en_q,
                          e_clock_stretch_enable_q};
        end else if (sel_stat) begin
          REG_RDATA_O <= {5'h00, mode_written_q,
                          (state_q != ST_IDLE), bdm_active_q};
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // port k and port e pins
  // -----------------------------------------------------------------
  assign PORT_K_PIN_O    = port_k_output_latch_q;
  assign PORT_K_PIN_OE_O = port_k_pin_direction_q;
  // interrupts are inhibited at reset, so both pins start as inputs
  assign PORT_E_PULLUP_O     = pullup_q;
  assign MASKABLE_IRQ_N_O    = PORT_E_PIN_I[1] || !IRQ_ENABLE_I;
  assign NONMASKABLE_IRQ_N_O = PORT_E_PIN_I[0] || !NONMASKABLE_INTERRUPT_INPUT_ENABLE_I;

  // -----------------------------------------------------------------
  // pipe status pins, floating while the mode is being sampled
  // -----------------------------------------------------------------
  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      PIPE_STATUS_HIGH_O <= 1'b0;
      PIPE_STATUS_LOW_O  <= 1'b0;
    end else begin
      PIPE_STATUS_HIGH_O <= PIPE_STATE_I[1];
      PIPE_STATUS_LOW_O  <= PIPE_STATE_I[0];
    end
  end

  assign PIPE_STATUS_OE_O = RESETN_I && !in_reset_q && pipe_en_q &&
                            !single_chip;

  // -----------------------------------------------------------------
  // timer reference, independent of any bus stretch
  // -----------------------------------------------------------------
  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      REF_TICK_O <= 1'b0;
      e_free_q   <= 1'b0;
    end else begin
      REF_TICK_O <= !REF_TICK_O;
      e_free_q   <= !e_free_q;
    end
  end

  // -----------------------------------------------------------------
  // external bus cycle sequencer
  // -----------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (BUS_REQ_I) begin
          state_d = ST_ADDR;
        end
      end
      ST_ADDR: begin
        state_d = ST_DATA;
      end
      ST_DATA: begin
        if (stretch_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  assign data_load = (state_q == ST_ADDR);
  assign swap      = req_wide_q && req_addr_q[0] && req_ram_q;
  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      state_q     <= ST_IDLE;
      req_wr_q    <= 1'b0;
      req_wide_q  <= 1'b0;
      req_ram_q   <= 1'b0;
      req_addr_q  <= 16'h0000;
      req_wdata_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      if ((state_q == ST_IDLE) && BUS_REQ_I) begin
        req_wr_q    <= BUS_WR_I;
        req_wide_q  <= BUS_WIDE_I;
        req_ram_q   <= BUS_RAM_I;
        req_addr_q  <= BUS_ADDR_I;
        req_wdata_q <= BUS_WDATA_I;
      end
    end
  end

  // multiplexed bus: address then data, data kept through stretch
  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      EXT_AD_O <= 16'h0000;
    end else if ((state_q == ST_IDLE) && BUS_REQ_I) begin
      EXT_AD_O <= BUS_ADDR_I;
    end else if (data_load) begin
      EXT_AD_O <= swap ? {req_wdata_q[7:0], req_wdata_q[15:8]} :
                         req_wdata_q;
    end
  end

  assign EXT_AD_OE_O = (state_q == ST_ADDR) ||
                       ((state_q == ST_DATA) && req_wr_q);
  ebms_stretch u_stretch (
    .clk_i     (CLK_SYS_I),
    .rst_n_i   (RESETN_I),
    .load_i    (data_load),
    .count_i   (STRETCH_CNT_I),
    .expired_o (stretch_done)
  );

  // read data taken at the end of the data phase, where the bus e clock falls
  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      BUS_RDATA_O       <= 16'h0000;
      BUS_RDATA_VALID_O <= 1'b0;
    end else begin
      BUS_RDATA_VALID_O <= 1'b0;
      if ((state_q == ST_DATA) && stretch_done && !req_wr_q) begin
        BUS_RDATA_O <= swap ? {EXT_AD_I[7:0], EXT_AD_I[15:8]} :
                              EXT_AD_I;
        BUS_RDATA_VALID_O <= 1'b1;
      end
    end
  end

  assign BUS_READY_O = (state_q == ST_IDLE);
  assign CPU_HOLD_O  = (state_q == ST_DATA) && !stretch_done;
  // access encoding; a misaligned word only comes from internal ram
  assign LOW_BYTE_STROBE_N_O = req_wide_q ? (req_addr_q[0] && req_ram_q) :
                                            !req_addr_q[0];
  assign ADDRESS_BIT_ZERO_O  = req_addr_q[0];
  assign READ_NOT_WRITE_O    = (state_q == ST_IDLE) || !req_wr_q;
  assign CHIP_SELECT_O       = (state_q != ST_IDLE);
  // stretch bit has no effect in single chip modes
  assign E_CLOCK_O = (e_clock_stretch_enable_q && !single_chip) ?
                     (state_q == ST_DATA) : e_free_q;

endmodule
`default_nettype wire

// ===== pkg/ebms_map.vh
// constants for the external bus mode and stretch block
// assumes inclusion by the design files and the bench; definitions, no logic
`ifndef EBMS_MAP_VH
`define EBMS_MAP_VH

// -----------------------------------------------------------------
// register offsets on the plain register port
// -----------------------------------------------------------------
`define EBMS_OFS_PORT_K_OUTPUT_LATCH_DIR   4'h0
`define EBMS_OFS_PORT_K_OUTPUT_LATCH_DATA  4'h1
`define EBMS_OFS_MODE        4'h2
`define EBMS_OFS_BUS_CTL     4'h3
`define EBMS_OFS_STATUS      4'h4

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define EBMS_MODE_EMK_BIT    0
`define EBMS_MODE_LO_BIT     5
`define EBMS_MODE_HI_BIT     7
`define EBMS_CTL_E_CLOCK_STRETCH_ENABLE_BIT    0
`define EBMS_CTL_PIPE_BIT    1
`define EBMS_CTL_PU0_BIT     2
`define EBMS_CTL_PU1_BIT     3

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define EBMS_RST_PORT_K_OUTPUT_LATCH_DIR   8'h00
`define EBMS_RST_PORT_K_OUTPUT_LATCH_DATA  8'h00
`define EBMS_RST_MODE        3'h0
`define EBMS_RST_E_CLOCK_STRETCH_ENABLE        1'b1
`define EBMS_RST_PULLUP      2'h3

// -----------------------------------------------------------------
// operating modes, pin c in the top bit
// -----------------------------------------------------------------
`define EBMS_MD_SPEC_SINGLE  3'h0
`define EBMS_MD_EMU_NARROW   3'h1
`define EBMS_MD_SPEC_TEST    3'h2
`define EBMS_MD_EMU_WIDE     3'h3
`define EBMS_MD_NORM_SINGLE  3'h4
`define EBMS_MD_NORM_NARROW  3'h5
`define EBMS_MD_PERIPHERAL   3'h6
`define EBMS_MD_NORM_WIDE    3'h7

// -----------------------------------------------------------------
// timing: stretch counter width and largest stretch
// -----------------------------------------------------------------
`define EBMS_STRETCH_W       2
`define EBMS_STRETCH_MAX     2'h3

`endif
